// >>> verification/sier_host_model.sv
// host side model: pulled-up interrupt inputs and which line the host sees asserted
`timescale 1ns/1ps
module sier_host_model
(
   input  wire logic  first_i,
   input  wire logic  first_oe_i,
   input  wire logic  second_i,
   input  wire logic  second_oe_i,
   input  wire logic  polarity_i,
   output logic [1:0] seen_o
);
   logic [1:0] lvl;
   // a released line floats up through the board pull-up
   assign lvl = {second_oe_i ? second_i : 1'b1, first_oe_i ? first_i : 1'b1};
   // active level decides; the host then reads the source flags
   assign seen_o = {lvl[1] == polarity_i, lvl[0] == polarity_i};
endmodule : sier_host_model

// >>> verification/sier_irq_route_monitor.sv
// checker: port-level properties of the interrupt routing stage
`timescale 1ns/1ps
module sier_irq_route_monitor
   import sier_pkg::*;
(
   input wire logic          clk_sys_i,
   input wire logic          srst_i,
   input wire logic [7:0]    reg_addr_i,
   input wire logic          reg_wr_i,
   input wire logic [7:0]    reg_wdata_i,
   input wire logic          reg_rd_i,
   input wire logic [7:0]    reg_rdata_o,
   input wire logic          sleep_wake_transition_i,
   input wire sier_mag_evt_t mag_threshold_i,
   input wire sier_mag_evt_t mag_vecm_i,
   input wire logic          irq_polarity_i,
   input wire logic          irq_output_drive_select_i,
   input wire logic          irq_pin_first_o,
   input wire logic          irq_pin_first_oe_o,
   input wire logic          irq_pin_second_o,
   input wire logic          irq_pin_second_oe_o,
   input wire logic          sleep_wake_event_o
);
   default clocking dc @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   // a read of the system mode register is the only clear of the sticky event besides reset
   wire logic mode_rd = reg_rd_i && reg_addr_i == ADDR_SYSTEM_MODE;
   AST_RST_RD: assert property ($fell(srst_i) && reg_rd_i && reg_addr_i == ADDR_SRC_ENABLES
      |=> reg_rdata_o == RST_SRC_ENABLES)
      else $error("enables not zero after reset");
   AST_WR_RD: assert property (reg_wr_i && reg_addr_i == ADDR_SRC_ENABLES ##1 !reg_wr_i
      ##1 reg_rd_i && reg_addr_i == ADDR_SRC_ENABLES |=> reg_rdata_o == $past(reg_wdata_i, 3))
      else $error("enable byte readback wrong");
   AST_SW_SET: assert property (sleep_wake_transition_i |=> sleep_wake_event_o)
      else $error("sleep event not set");
   AST_SW_HOLD: assert property (sleep_wake_event_o && !mode_rd |=> sleep_wake_event_o)
      else $error("sleep event dropped early");
   AST_SW_CLR: assert property (sleep_wake_event_o && mode_rd && !sleep_wake_transition_i |=> !sleep_wake_event_o)
      else $error("sleep event not cleared");
   AST_OD: assert property (irq_output_drive_select_i |=> !irq_pin_first_o && !irq_pin_second_o)
      else $error("open-drain pin drives high");
   AST_PP: assert property (!irq_output_drive_select_i |=> irq_pin_first_oe_o && irq_pin_second_oe_o)
      else $error("push-pull pin released");
   AST_MAG_FIRST: assert property (mag_threshold_i == 3'b111 && !irq_output_drive_select_i
      |=> irq_pin_first_o == $past(irq_polarity_i))
      else $error("threshold event missing on first pin");
   AST_MAG_SECOND: assert property (mag_vecm_i == 3'b110 && !irq_output_drive_select_i
      |=> irq_pin_second_o == $past(irq_polarity_i))
      else $error("vector event missing on second pin");
   cover property (mag_threshold_i == 3'b111);
   cover property (sleep_wake_event_o ##1 !sleep_wake_event_o);
   cover property (irq_output_drive_select_i && irq_polarity_i);
   cover property (mode_rd && sleep_wake_transition_i);
endmodule : sier_irq_route_monitor
bind sier_irq_route sier_irq_route_monitor u_mon (.*);

// >>> verification/sier_irq_route_tb.sv
// testbench: registers, routing, pin modes, sleep/wake and magnetic events
`timescale 1ns/1ps
module sier_irq_route_tb
   import sier_pkg::*;
;
   logic clk_sys_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, sleep_wake_transition_i = 1'b0;
   logic irq_polarity_i = 1'b0, irq_output_drive_select_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, event_flags_i = 8'h00, reg_rdata_o;
   sier_mag_evt_t mag_threshold_i = '0, mag_vecm_i = '0;
   logic irq_pin_first_o, irq_pin_first_oe_o, irq_pin_second_o, irq_pin_second_oe_o, sleep_wake_event_o;
   logic [1:0] seen;
   int err_total = 0, samples_checked = 0, cycles = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   sier_irq_route u_dut (.*);
   sier_host_model u_host (.first_i(irq_pin_first_o), .first_oe_i(irq_pin_first_oe_o), .second_i(irq_pin_second_o),
      .second_oe_i(irq_pin_second_oe_o), .polarity_i(irq_polarity_i), .seen_o(seen));
   task automatic stop_test();
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   // hang guard, twenty times the hundred or so cycles the run needs
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         err_total++;
         stop_test();
      end
   end
   task automatic tick();
      @(posedge clk_sys_i);
      #1;
   endtask : tick
   task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t byte %h exp %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pin(logic [1:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %0t pins %b exp %b", $time, seen, exp);
      end
   endtask : chk_pin
   // strobes drop after their edge and one idle edge follows
   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      tick();
      reg_wr_i = 1'b0;
      tick();
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] exp);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      tick();
      reg_rd_i = 1'b0;
      chk_reg(reg_rdata_o, exp);
      tick();
   endtask : rd
   task automatic pins(logic [7:0] f, logic [1:0] exp);
      event_flags_i = f;
      tick();
      chk_pin(exp);
   endtask : pins
   task automatic t_regs();
      rd(8'h2d, 8'h00);
      rd(8'h2e, 8'h00);
      wr(8'h2d, 8'ha5);
      rd(8'h2d, 8'ha5);
      wr(8'h2e, 8'h5a);
      rd(8'h2e, 8'h5a);
      rd(8'h2f, 8'h00);
   endtask : t_regs
   // each source of bits 0 to 6 alone, odd bits to the first pin; other raised flags stay masked
   task automatic t_route();
      for (int i = 0; i < 7; i++)
      begin
         wr(8'h2d, 8'h01 << i);
         wr(8'h2e, i[0] ? 8'h01 << i : 8'h00);
         pins(8'h7f, i[0] ? 2'b01 : 2'b10);
         pins(8'h7f & ~(8'h01 << i), 2'b00);
      end
      wr(8'h2d, 8'h0f);
      wr(8'h2e, 8'h05);
      pins(8'h03, 2'b11);
      pins(8'h05, 2'b01);
   endtask : t_route
   task automatic t_mode();
      wr(8'h2d, 8'h01);
      wr(8'h2e, 8'h01);
      pins(8'h01, 2'b01);
      for (int m = 0; m < 4; m++)
      begin
         {irq_polarity_i, irq_output_drive_select_i} = m[1:0];
         tick();
         chk_pin(2'b01);
      end
      {irq_polarity_i, irq_output_drive_select_i} = 2'b00;
   endtask : t_mode
   // raw bit 7 flag must not count, only the latched transition
   task automatic t_sleep();
      wr(8'h2d, 8'h80);
      wr(8'h2e, 8'h80);
      pins(8'h80, 2'b00);
      sleep_wake_transition_i = 1'b1;
      tick();
      sleep_wake_transition_i = 1'b0;
      tick();
      chk_pin(2'b01);
      chk_reg({7'h00, sleep_wake_event_o}, 8'h01);
      // a transition in the cycle of the clearing read must survive it
      sleep_wake_transition_i = 1'b1;
      reg_addr_i = ADDR_SYSTEM_MODE;
      reg_rd_i = 1'b1;
      tick();
      sleep_wake_transition_i = 1'b0;
      reg_rd_i = 1'b0;
      tick();
      chk_reg({7'h00, sleep_wake_event_o}, 8'h01);
      rd(8'h0b, 8'h00);
      chk_pin(2'b00);
   endtask : t_sleep
   task automatic t_mag();
      wr(8'h2d, 8'h00);
      mag_threshold_i = 3'b111;
      mag_vecm_i = 3'b110;
      pins(8'hff, 2'b11);
      mag_threshold_i = 3'b101;
      pins(8'hff, 2'b10);
      mag_vecm_i = 3'b000;
   endtask : t_mag
   task automatic t_reset();
      wr(8'h2e, 8'hff);
      srst_i = 1'b1;
      tick();
      srst_i = 1'b0;
      rd(8'h2d, 8'h00);
      rd(8'h2e, 8'h00);
      chk_pin(2'b00);
      wr(8'h2d, 8'h01);
      pins(8'h01, 2'b10);
   endtask : t_reset
   initial
   begin
      repeat (4) tick();
      srst_i = 1'b0;
      t_regs();
      t_route();
      t_mode();
      t_sleep();
      t_mag();
      t_reset();
      stop_test();
   end
endmodule : sier_irq_route_tb

// >>> verilog/sier_irq_route.sv
// module: interrupt enable and routing stage with its two configuration registers
`timescale 1ns/1ps
module sier_irq_route
   import sier_pkg::*;
(
   input  wire logic                clk_sys_i,
   input  wire logic                srst_i,
   // register access port
   input  wire logic [7:0]          reg_addr_i,
   input  wire logic                reg_wr_i,
   input  wire logic [7:0]          reg_wdata_i,
   input  wire logic                reg_rd_i,
   output logic      [7:0]          reg_rdata_o,
   // event flags from the functional blocks, bit order of the enable byte
   input  wire logic [NUM_SRC-1:0]  event_flags_i,
   input  wire logic                sleep_wake_transition_i,
   // magnetic events with their own configuration
   input  wire sier_mag_evt_t       mag_threshold_i,
   input  wire sier_mag_evt_t       mag_vecm_i,
   // pin modes
   input  wire logic                irq_polarity_i,
   input  wire logic                irq_output_drive_select_i,
   // pins as two signals each, level and output enable
   output logic                     irq_pin_first_o,
   output logic                     irq_pin_first_oe_o,
   output logic                     irq_pin_second_o,
   output logic                     irq_pin_second_oe_o,
   // sticky sleep/wake event for the source register
   output logic                     sleep_wake_event_o
);

   // configuration registers and their next values
   logic [7:0]           src_en_q;
   logic [7:0]           src_en_d;
   logic [7:0]           route_q;
   logic [7:0]           route_d;
   logic [7:0]           rdata_q;
   logic [7:0]           rdata_d;
   logic                 slp_evt_q;
   logic                 slp_evt_d;
   logic [NUM_SRC-1:0]   flags;
   logic [NUM_SRC-1:0]   gated;
   // per-source and magnetic steering terms, one bit per source
   logic [NUM_SRC-1:0]   to_first;
   logic [NUM_SRC-1:0]   to_second;
   logic [1:0]           mag_gated;
   logic [1:0]           mag_first;
   logic [1:0]           mag_second;
   logic [NUM_PINS-1:0]  pin_assert;
   logic                 wr_src_en;
   logic                 wr_route;
   logic                 rd_mode;
   sier_pin_t            pin_drv [NUM_PINS];
   sier_pin_t            pin_q   [NUM_PINS];
   sier_pin_t            pin_d   [NUM_PINS];

   // one-hot address hit, used by write, read and clear paths
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
      addr_hit = (addr == target);
   endfunction : addr_hit

   // one event onto one pin: true only when its routing bit names that pin;
   // shared by the accelerometer sources and the two magnetic ones
   function automatic logic steer(input logic evt, input logic route, input logic want);
      steer = evt && (route == want);
   endfunction : steer

   // read data for one address; the mode register is only a clear trigger here,
   // so it reads back zero like any unmapped address
   function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] en, input logic [7:0] rt);
      if (addr_hit(addr, ADDR_SRC_ENABLES))
         read_mux = en;
      else if (addr_hit(addr, ADDR_PIN_ROUTING))
         read_mux = rt;
      else
         read_mux = 8'h00;
   endfunction : read_mux

   // decoded strobes, shared by the register and sleep/wake paths;
   // writes to other addresses are dropped without any indication
   always_comb
   begin
      wr_src_en = reg_wr_i && addr_hit(reg_addr_i, ADDR_SRC_ENABLES);
      wr_route  = reg_wr_i && addr_hit(reg_addr_i, ADDR_PIN_ROUTING);
      rd_mode   = reg_rd_i && addr_hit(reg_addr_i, ADDR_SYSTEM_MODE);
   end

   // register next values; writes take effect on the next edge
   always_comb
   begin
      src_en_d = src_en_q;
      route_d  = route_q;
      rdata_d  = rdata_q;
      if (wr_src_en)
         src_en_d = reg_wdata_i;
      if (wr_route)
         route_d = reg_wdata_i;
      // a read in the same cycle as a write returns the old byte
      if (reg_rd_i)
         rdata_d = read_mux(reg_addr_i, src_en_q, route_q);
   end

   // reset leaves every source off and steered to the second pin
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         src_en_q <= RST_SRC_ENABLES;
         route_q  <= RST_PIN_ROUTING;
         rdata_q  <= 8'h00;
      end
      else
      begin
         src_en_q <= src_en_d;
         route_q  <= route_d;
         rdata_q  <= rdata_d;
      end
   end

   // sleep/wake latch: a transition in the clearing cycle wins, so none is lost;
   // the price is that the host may find the event set again right after its read
   always_comb
   begin
      slp_evt_d = slp_evt_q;
      if (rd_mode)
         slp_evt_d = 1'b0;
      if (sleep_wake_transition_i)
         slp_evt_d = 1'b1;
   end

   // sticky event register
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
         slp_evt_q <= 1'b0;
      else
         slp_evt_q <= slp_evt_d;
   end

   // the latched sleep/wake event replaces the raw flag at its position,
   // so a short mode pulse cannot be missed by a slow host
   always_comb
   begin
      flags                 = event_flags_i;
      flags[BIT_SLEEP_WAKE] = slp_evt_q;
   end

   // gate each accelerometer source by its enable, then split it by its routing bit;
   // a disabled source yields zero on both steering terms
   always_comb
   begin
      gated     = flags & src_en_q;
      to_first  = '0;
      to_second = '0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         to_first[i]  = steer(gated[i], route_q[i], ROUTE_TO_FIRST);
         to_second[i] = steer(gated[i], route_q[i], ROUTE_TO_SECOND);
      end
   end

   // magnetic sources carry enable and routing bits held outside this block;
   // index 0 is the threshold event, index 1 the vector-magnitude event
   always_comb
   begin
      mag_gated[0]  = mag_threshold_i.flag & mag_threshold_i.enable;
      mag_gated[1]  = mag_vecm_i.flag & mag_vecm_i.enable;
      mag_first[0]  = steer(mag_gated[0], mag_threshold_i.route, ROUTE_TO_FIRST);
      mag_second[0] = steer(mag_gated[0], mag_threshold_i.route, ROUTE_TO_SECOND);
      mag_first[1]  = steer(mag_gated[1], mag_vecm_i.route, ROUTE_TO_FIRST);
      mag_second[1] = steer(mag_gated[1], mag_vecm_i.route, ROUTE_TO_SECOND);
   end

   // each pin is the OR of everything steered to it, so several sources share a pin
   // and only the source register tells them apart
   always_comb
   begin
      pin_assert[PIN_FIRST]  = (|to_first) | (|mag_first);
      pin_assert[PIN_SECOND] = (|to_second) | (|mag_second);
   end

   // pin drivers, registered so the pins are glitch-free; one clock of latency;
   // the reset value assumes the default active-low mode, so a host set up for
   // active high sees the pins asserted while reset is held
   generate
      for (genvar p = 0; p < NUM_PINS; p++)
      begin : g_pin
         sier_pin_drive u_drive (
            .assert_i    (pin_assert[p]),
            .polarity_i  (irq_polarity_i),
            .drive_sel_i (irq_output_drive_select_i),
            .pin_o       (pin_drv[p])
         );

         always_comb
         begin
            pin_d[p] = pin_drv[p];
         end

         always_ff @(posedge clk_sys_i)
         begin
            if (srst_i)
            begin
               pin_q[p] <= PIN_RST; // inactive, active-low push-pull default
            end
            else
            begin
               pin_q[p] <= pin_d[p];
            end
         end
      end
   endgenerate

   // outputs straight from flip-flops
   assign irq_pin_first_o     = pin_q[PIN_FIRST].out;
   assign irq_pin_first_oe_o  = pin_q[PIN_FIRST].oe;
   assign irq_pin_second_o    = pin_q[PIN_SECOND].out;
   assign irq_pin_second_oe_o = pin_q[PIN_SECOND].oe;
   assign sleep_wake_event_o  = slp_evt_q;
   assign reg_rdata_o         = rdata_q;

endmodule : sier_irq_route

// >>> verilog/sier_pin_drive.sv
// module: one interrupt pin driver with polarity and push-pull/open-drain selection
`timescale 1ns/1ps
module sier_pin_drive
   import sier_pkg::*;
(
   input  wire logic      assert_i,
   input  wire logic      polarity_i,
   input  wire logic      drive_sel_i,
   output sier_pin_t      pin_o
);

   logic level;

   // electrical level follows polarity
   always_comb
   begin
      level = (polarity_i == POL_ACTIVE_LOW) ? ~assert_i : assert_i;
      if (drive_sel_i == DRIVE_PUSH_PULL)
      begin
         pin_o.out = level;
         pin_o.oe  = 1'b1;
      end
      else
      begin
         // open-drain only pulls low; the pullup makes the high level
         pin_o.out = 1'b0;
         pin_o.oe  = ~level;
      end
   end

endmodule : sier_pin_drive

// >>> verilog/sier_pkg.sv
// package: register map, field positions and pin drive type for the interrupt routing stage
// Functional notes
// - an event flag reaches the pin logic only while its enable bit is set, otherwise it touches neither pin.
// - eight enable bits sit in one read/write byte, bit 7 sleep/wake down to bit 0 data-ready, 1 enables.
// - an enabled event goes to the second pin when its routing bit is 0 and to the first pin when it is 1.
// - eight routing bits sit in a second read/write byte with the same bit order as the enable byte.
// - each pin carries the OR of every enabled event steered to it.
// - magnetic threshold and magnetic vector-magnitude events are gated by their own external enable bits.
// - those two magnetic events are steered by their own routing bits and ORed onto the chosen pin.
// - after reset every enable and routing bit is zero, so all sources are off and default to the second pin.
// - both pins are active low when the polarity bit is 0 and active high when it is 1.
// - both pins are push-pull when the drive select bit is 0 and open-drain when it is 1.
// - the sleep/wake event stays asserted after a mode transition until the system mode register is read.
package sier_pkg;

   localparam int unsigned NUM_SRC = 8;

   // register addresses
   localparam logic [7:0] ADDR_SRC_ENABLES  = 8'h2d;
   localparam logic [7:0] ADDR_PIN_ROUTING  = 8'h2e;
   localparam logic [7:0] ADDR_SYSTEM_MODE  = 8'h0b;

   // reset values
   localparam logic [7:0] RST_SRC_ENABLES   = 8'h00;
   localparam logic [7:0] RST_PIN_ROUTING   = 8'h00;

   // bit positions shared by enable and routing bytes
   localparam int unsigned BIT_SLEEP_WAKE   = 7;
   localparam int unsigned BIT_FIFO         = 6;
   localparam int unsigned BIT_TRANSIENT    = 5;
   localparam int unsigned BIT_ORIENT       = 4;
   localparam int unsigned BIT_PULSE        = 3;
   localparam int unsigned BIT_FFMT         = 2;
   localparam int unsigned BIT_ACC_VECM     = 1;
   localparam int unsigned BIT_DATA_READY   = 0;

   // routing bit meaning
   localparam logic ROUTE_TO_FIRST          = 1'b1;
   localparam logic ROUTE_TO_SECOND         = 1'b0;

   // pin mode encodings
   localparam logic POL_ACTIVE_LOW          = 1'b0;
   localparam logic DRIVE_PUSH_PULL         = 1'b0;

   // pin indices
   localparam int unsigned PIN_FIRST        = 0;
   localparam int unsigned PIN_SECOND       = 1;
   localparam int unsigned NUM_PINS         = 2;

   // two-signal pin drive: level and output enable
   typedef struct packed {
      logic out;
      logic oe;
   } sier_pin_t;

   // external magnetic event with its own enable and routing
   typedef struct packed {
      logic flag;
      logic enable;
      logic route;
   } sier_mag_evt_t;

   localparam sier_pin_t PIN_RST            = '{out: 1'b1, oe: 1'b1};

endpackage : sier_pkg
